/* File: hw/scpi_pkg.sv */
/*
 shared constants, keyword table and types of the command header parser.
 assumes ASCII characters arrive at most one per clock, held while char_ready is low, from logic on the same clock.
*/
`default_nettype none
package scpi_pkg;
   localparam int KW_LEN = 12;
   localparam int KW_COUNT = 18;

   localparam logic [7:0] CH_STAR = 8'h2A;
   localparam logic [7:0] CH_COLON = 8'h3A;
   localparam logic [7:0] CH_SEMI = 8'h3B;
   localparam logic [7:0] CH_QUEST = 8'h3F;
   localparam logic [7:0] CH_SPACE = 8'h20;
   localparam logic [7:0] CH_COMMA = 8'h2C;
   localparam logic [7:0] CH_LF = 8'h0A;
   localparam logic [7:0] CH_LOW_A = 8'h61;
   localparam logic [7:0] CH_LOW_Z = 8'h7A;
   localparam logic [7:0] CH_UP_A = 8'h41;
   localparam logic [7:0] CH_UP_Z = 8'h5A;
   localparam logic [7:0] CASE_DIFF = 8'h20;

   localparam logic [4:0] KW_NONE = 5'h00;
   localparam logic [4:0] KW_INP = 5'h01;
   localparam logic [4:0] KW_COUP = 5'h02;
   localparam logic [4:0] KW_IMP = 5'h03;
   localparam logic [4:0] KW_SENS = 5'h04;
   localparam logic [4:0] KW_ROSC = 5'h05;
   localparam logic [4:0] KW_SOUR = 5'h06;
   localparam logic [4:0] KW_MEAS = 5'h07;
   localparam logic [4:0] KW_CONF = 5'h08;
   localparam logic [4:0] KW_READ = 5'h09;
   localparam logic [4:0] KW_INIT = 5'h0A;
   localparam logic [4:0] KW_IMM = 5'h0B;
   localparam logic [4:0] KW_FETC = 5'h0C;
   localparam logic [4:0] KW_RST = 5'h0D;
   localparam logic [4:0] KW_TST = 5'h0E;
   localparam logic [4:0] KW_STB = 5'h0F;
   localparam logic [4:0] KW_IDN = 5'h10;
   localparam logic [4:0] KW_CLS = 5'h11;
   localparam logic [4:0] KW_ESE = 5'h12;

   localparam logic [3:0] CMD_NONE = 4'h0;
   localparam logic [3:0] CMD_INP_COUP = 4'h1;
   localparam logic [3:0] CMD_INP_IMP = 4'h2;
   localparam logic [3:0] CMD_ROSC_SOUR = 4'h3;
   localparam logic [3:0] CMD_MEAS = 4'h4;
   localparam logic [3:0] CMD_CONF = 4'h5;
   localparam logic [3:0] CMD_READ = 4'h6;
   localparam logic [3:0] CMD_INIT = 4'h7;
   localparam logic [3:0] CMD_FETC = 4'h8;
   localparam logic [3:0] CMD_RST = 4'h9;
   localparam logic [3:0] CMD_TST = 4'hA;
   localparam logic [3:0] CMD_STB = 4'hB;
   localparam logic [3:0] CMD_IDN = 4'hC;
   localparam logic [3:0] CMD_CLS = 4'hD;
   localparam logic [3:0] CMD_ESE = 4'hE;

   localparam logic [2:0] ACT_CFG = 3'h4;
   localparam logic [2:0] ACT_INIT = 3'h2;
   localparam logic [2:0] ACT_FETCH = 3'h1;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_COMMON = 3'b001,
      ST_KEY = 3'b010,
      ST_HDR = 3'b011,
      ST_PARAM = 3'b100,
      ST_SKIP = 3'b101
   } scpi_state_e;

   typedef struct packed {
      logic [95:0] name;
      logic [3:0] slen;
      logic [3:0] flen;
   } scpi_kw_s;

   // full upper-case spelling, left aligned, with short and full lengths
   function automatic scpi_kw_s kw_entry(input logic [4:0] id);
      case (id)
         KW_INP: kw_entry = '{{"INPUT", 56'h0}, 4'h3, 4'h5};
         KW_COUP: kw_entry = '{{"COUPLING", 32'h0}, 4'h4, 4'h8};
         KW_IMP: kw_entry = '{{"IMPEDANCE", 24'h0}, 4'h3, 4'h9};
         KW_SENS: kw_entry = '{{"SENSE", 56'h0}, 4'h4, 4'h5};
         KW_ROSC: kw_entry = '{{"ROSCILLATOR", 8'h0}, 4'h4, 4'hB};
         KW_SOUR: kw_entry = '{{"SOURCE", 48'h0}, 4'h4, 4'h6};
         KW_MEAS: kw_entry = '{{"MEASURE", 40'h0}, 4'h4, 4'h7};
         KW_CONF: kw_entry = '{{"CONFIGURE", 24'h0}, 4'h4, 4'h9};
         KW_READ: kw_entry = '{{"READ", 64'h0}, 4'h4, 4'h4};
         KW_INIT: kw_entry = '{{"INITIATE", 32'h0}, 4'h4, 4'h8};
         KW_IMM: kw_entry = '{{"IMMEDIATE", 24'h0}, 4'h3, 4'h9};
         KW_FETC: kw_entry = '{{"FETCH", 56'h0}, 4'h4, 4'h5};
         KW_RST: kw_entry = '{{"RST", 72'h0}, 4'h3, 4'h3};
         KW_TST: kw_entry = '{{"TST", 72'h0}, 4'h3, 4'h3};
         KW_STB: kw_entry = '{{"STB", 72'h0}, 4'h3, 4'h3};
         KW_IDN: kw_entry = '{{"IDN", 72'h0}, 4'h3, 4'h3};
         KW_CLS: kw_entry = '{{"CLS", 72'h0}, 4'h3, 4'h3};
         KW_ESE: kw_entry = '{{"ESE", 72'h0}, 4'h3, 4'h3};
         default: kw_entry = '{96'h0, 4'hF, 4'hF};
      endcase
   endfunction : kw_entry
endpackage : scpi_pkg
`default_nettype wire

/* File: hw/scpi_kw_match.sv */
/*
 combinational keyword matcher: short or full form against the keyword table.
 assumes the buffer holds upper-cased characters, left aligned, len of them valid.
*/
`timescale 1ns/1ps
`default_nettype none
module scpi_kw_match (
   input wire logic [95:0] kw_buf,
   input wire logic [3:0] kw_len,
   output logic [4:0] kw_id,
   output logic kw_hit,
   output logic kw_bad_len
);
   always_comb begin
      scpi_pkg::scpi_kw_s e;
      logic pre;
      e = '0;
      pre = 1'b0;
      kw_id = scpi_pkg::KW_NONE;
      kw_hit = 1'b0;
      kw_bad_len = 1'b0;
      for (int k = 1; k <= scpi_pkg::KW_COUNT; k++) begin
         e = scpi_pkg::kw_entry(5'(k));
         pre = 1'b1;
         for (int i = 0; i < scpi_pkg::KW_LEN; i++) begin
            if (4'(i) < kw_len && kw_buf[95 - 8 * i -: 8] != e.name[95 - 8 * i -: 8]) begin
               pre = 1'b0;
            end
         end
         // short or full spelling only
         if (pre && (kw_len == e.slen || kw_len == e.flen)) begin
            kw_id = 5'(k);
            kw_hit = 1'b1;
         end else if (pre && kw_len > e.slen && kw_len < e.flen) begin
            kw_bad_len = 1'b1;
         end
      end
   end
endmodule : scpi_kw_match
`default_nettype wire

/* File: hw/scpi_header_parser.sv */
/*
 command header parser: splits ASCII program messages into header, data and
 terminator and turns measurement shortcuts into configure/initiate/fetch pulses.
 assumes the character source is on clk and honours char_ready.
*/
`timescale 1ns/1ps
`default_nettype none
module scpi_header_parser (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic char_valid,
   input wire logic [7:0] char_data,
   output logic char_ready,
   output logic cmd_valid,
   output logic [3:0] cmd_code,
   output logic cmd_query,
   output logic cmd_common,
   output logic cmd_error,
   output logic param_valid,
   output logic [7:0] param_char,
   output logic param_first,
   output logic param_sep,
   output logic act_cfg,
   output logic act_init,
   output logic act_fetch,
   output logic data_avail
);
   function automatic logic [7:0] upcase(input logic [7:0] c);
      upcase = (c >= scpi_pkg::CH_LOW_A && c <= scpi_pkg::CH_LOW_Z) ? c - scpi_pkg::CASE_DIFF : c;
   endfunction : upcase

   // tree walk with implicit optional root
   function automatic logic [3:0] path_cmd(input logic [4:0] k0, input logic [4:0] k1, input logic [4:0] k2,
                                           input logic [1:0] d);
      logic [4:0] a;
      logic [4:0] b;
      logic [4:0] c;
      logic [1:0] n;
      a = k0;
      b = k1;
      c = k2;
      n = d;
      if (a == scpi_pkg::KW_ROSC && d != 2'h3) begin
         c = b;
         b = a;
         a = scpi_pkg::KW_SENS;
         n = d + 2'h1;
      end
      path_cmd = scpi_pkg::CMD_NONE;
      case (n)
         2'h1: begin
            case (a)
               scpi_pkg::KW_MEAS: path_cmd = scpi_pkg::CMD_MEAS;
               scpi_pkg::KW_CONF: path_cmd = scpi_pkg::CMD_CONF;
               scpi_pkg::KW_READ: path_cmd = scpi_pkg::CMD_READ;
               scpi_pkg::KW_INIT: path_cmd = scpi_pkg::CMD_INIT;
               scpi_pkg::KW_FETC: path_cmd = scpi_pkg::CMD_FETC;
               default: path_cmd = scpi_pkg::CMD_NONE;
            endcase
         end
         2'h2: begin
            if (a == scpi_pkg::KW_INP && b == scpi_pkg::KW_COUP) path_cmd = scpi_pkg::CMD_INP_COUP;
            if (a == scpi_pkg::KW_INP && b == scpi_pkg::KW_IMP) path_cmd = scpi_pkg::CMD_INP_IMP;
            if (a == scpi_pkg::KW_INIT && b == scpi_pkg::KW_IMM) path_cmd = scpi_pkg::CMD_INIT;
         end
         2'h3: begin
            if (a == scpi_pkg::KW_SENS && b == scpi_pkg::KW_ROSC && c == scpi_pkg::KW_SOUR) begin
               path_cmd = scpi_pkg::CMD_ROSC_SOUR;
            end
         end
         default: path_cmd = scpi_pkg::CMD_NONE;
      endcase
   endfunction : path_cmd

   function automatic logic [3:0] common_code(input logic [4:0] k);
      case (k)
         scpi_pkg::KW_RST: common_code = scpi_pkg::CMD_RST;
         scpi_pkg::KW_TST: common_code = scpi_pkg::CMD_TST;
         scpi_pkg::KW_STB: common_code = scpi_pkg::CMD_STB;
         scpi_pkg::KW_IDN: common_code = scpi_pkg::CMD_IDN;
         scpi_pkg::KW_CLS: common_code = scpi_pkg::CMD_CLS;
         scpi_pkg::KW_ESE: common_code = scpi_pkg::CMD_ESE;
         default: common_code = scpi_pkg::CMD_NONE;
      endcase
   endfunction : common_code

   // which commands must or must not be queries
   function automatic logic query_ok(input logic [3:0] code, input logic q);
      case (code)
         scpi_pkg::CMD_MEAS, scpi_pkg::CMD_READ, scpi_pkg::CMD_FETC, scpi_pkg::CMD_TST, scpi_pkg::CMD_STB,
         scpi_pkg::CMD_IDN: query_ok = q;
         scpi_pkg::CMD_CONF, scpi_pkg::CMD_INIT, scpi_pkg::CMD_RST, scpi_pkg::CMD_CLS: query_ok = !q;
         default: query_ok = 1'b1;
      endcase
   endfunction : query_ok

   scpi_pkg::scpi_state_e st_reg, st_next;
   logic [95:0] buf_reg, buf_next;
   logic [3:0] len_reg, len_next;
   logic [1:0] depth_reg, depth_next, pdepth_reg, pdepth_next;
   logic [4:0] p0_reg, p0_next, p1_reg, p1_next, p2_reg, p2_next, par0_reg, par0_next, par1_reg, par1_next;
   logic query_reg, query_next, common_reg, common_next, first_reg, first_next;
   logic [3:0] code_reg, code_next, ccode_reg;
   logic [2:0] pend_reg, pend_next;
   logic ready_reg, cv_reg, cq_reg, cc_reg, ce_reg, pv_reg, pf_reg, ps_reg, cfg_reg, init_reg, fetch_reg, avail_reg;
   logic [7:0] pc_reg;
   logic emit;
   logic [3:0] emit_code;
   logic emit_err;

   wire acc = char_valid & ready_reg;
   wire [7:0] ch_up = upcase(char_data);
   wire is_letter = ch_up >= scpi_pkg::CH_UP_A && ch_up <= scpi_pkg::CH_UP_Z;
   wire is_end = char_data == scpi_pkg::CH_LF || char_data == scpi_pkg::CH_SEMI;
   wire in_name = st_reg == scpi_pkg::ST_KEY || st_reg == scpi_pkg::ST_COMMON;
   wire [95:0] buf_app = buf_reg | ({ch_up, 88'h0} >> (8 * len_reg));
   wire [4:0] kw_id;
   wire kw_hit;
   wire kw_bad;

   scpi_kw_match u_match (
      .kw_buf(buf_reg),
      .kw_len(len_reg),
      .kw_id(kw_id),
      .kw_hit(kw_hit),
      .kw_bad_len(kw_bad)
   );

   // path with the finished keyword appended
   wire overflow = !common_reg && depth_reg == 2'h3;
   wire [4:0] np0 = depth_reg == 2'h0 ? kw_id : p0_reg;
   wire [4:0] np1 = depth_reg == 2'h1 ? kw_id : p1_reg;
   wire [4:0] np2 = depth_reg == 2'h2 ? kw_id : p2_reg;
   wire [1:0] ndepth = depth_reg + 2'h1;
   wire hdr_query = query_reg | char_data == scpi_pkg::CH_QUEST;
   wire [3:0] hdr_code = common_reg ? common_code(kw_id) : path_cmd(np0, np1, np2, ndepth);
   wire kw_fail = !kw_hit || kw_bad || overflow;
   wire hdr_bad = kw_fail || hdr_code == scpi_pkg::CMD_NONE || !query_ok(hdr_code, hdr_query);
   wire [4:0] ep0 = in_name ? np0 : p0_reg;
   wire [4:0] ep1 = in_name ? np1 : p1_reg;
   wire [1:0] edepth = in_name ? ndepth : depth_reg;

   always_comb begin
      st_next = st_reg;
      buf_next = buf_reg;
      len_next = len_reg;
      depth_next = depth_reg;
      p0_next = p0_reg;
      p1_next = p1_reg;
      p2_next = p2_reg;
      par0_next = par0_reg;
      par1_next = par1_reg;
      pdepth_next = pdepth_reg;
      query_next = query_reg;
      common_next = common_reg;
      code_next = code_reg;
      first_next = first_reg;
      emit = 1'b0;
      emit_code = scpi_pkg::CMD_NONE;
      emit_err = 1'b0;
      if (acc) begin
         case (st_reg)
            scpi_pkg::ST_IDLE: begin
               query_next = 1'b0;
               common_next = 1'b0;
               len_next = 4'h0;
               buf_next = '0;
               if (char_data == scpi_pkg::CH_STAR) begin
                  common_next = 1'b1;
                  st_next = scpi_pkg::ST_COMMON;
               end else if (char_data == scpi_pkg::CH_COLON) begin
                  depth_next = 2'h0;
                  st_next = scpi_pkg::ST_KEY;
               end else if (is_letter) begin
                  depth_next = pdepth_reg;
                  p0_next = par0_reg;
                  p1_next = par1_reg;
                  buf_next = {ch_up, 88'h0};
                  len_next = 4'h1;
                  st_next = scpi_pkg::ST_KEY;
               end else if (!is_end && char_data != scpi_pkg::CH_SPACE) begin
                  st_next = scpi_pkg::ST_SKIP;
               end
            end
            scpi_pkg::ST_COMMON, scpi_pkg::ST_KEY: begin
               if (is_letter && len_reg != 4'(scpi_pkg::KW_LEN)) begin
                  buf_next = buf_app;
                  len_next = len_reg + 4'h1;
               end else if (char_data == scpi_pkg::CH_COLON && !common_reg && !kw_fail) begin
                  p0_next = np0;
                  p1_next = np1;
                  p2_next = np2;
                  depth_next = ndepth;
                  buf_next = '0;
                  len_next = 4'h0;
               end else if ((char_data == scpi_pkg::CH_QUEST || char_data == scpi_pkg::CH_SPACE || is_end)
                            && !hdr_bad) begin
                  p0_next = np0;
                  p1_next = np1;
                  p2_next = np2;
                  depth_next = ndepth;
                  code_next = hdr_code;
                  query_next = hdr_query;
                  first_next = 1'b1;
                  if (char_data == scpi_pkg::CH_QUEST) st_next = scpi_pkg::ST_HDR;
                  else if (char_data == scpi_pkg::CH_SPACE) st_next = scpi_pkg::ST_PARAM;
                  emit = is_end;
                  emit_code = hdr_code;
               end else if (is_end) begin
                  emit = 1'b1;
                  emit_err = 1'b1;
               end else begin
                  st_next = scpi_pkg::ST_SKIP;
               end
            end
            scpi_pkg::ST_HDR: begin
               if (char_data == scpi_pkg::CH_SPACE) st_next = scpi_pkg::ST_PARAM;
               else if (!is_end) st_next = scpi_pkg::ST_SKIP;
               emit = is_end;
               emit_code = code_reg;
            end
            scpi_pkg::ST_PARAM: begin
               if (char_data != scpi_pkg::CH_COMMA && !is_end) first_next = 1'b0;
               emit = is_end;
               emit_code = code_reg;
            end
            scpi_pkg::ST_SKIP: begin
               emit = is_end;
               emit_err = 1'b1;
            end
            default: st_next = scpi_pkg::ST_IDLE;
         endcase
         if (emit) begin
            st_next = scpi_pkg::ST_IDLE;
            if (char_data == scpi_pkg::CH_LF) begin
               pdepth_next = 2'h0;
            end else if (!emit_err && !common_reg) begin
               par0_next = ep0;
               par1_next = ep1;
               pdepth_next = edepth - 2'h1;
            end
         end
      end
      pend_next = pend_reg & ~(pend_reg[2] ? scpi_pkg::ACT_CFG : pend_reg[1] ? scpi_pkg::ACT_INIT : pend_reg);
      if (emit && !emit_err) begin
         case (emit_code)
            scpi_pkg::CMD_MEAS: pend_next = scpi_pkg::ACT_CFG | scpi_pkg::ACT_INIT | scpi_pkg::ACT_FETCH;
            scpi_pkg::CMD_READ: pend_next = scpi_pkg::ACT_INIT | scpi_pkg::ACT_FETCH;
            scpi_pkg::CMD_CONF: pend_next = scpi_pkg::ACT_CFG;
            scpi_pkg::CMD_INIT: pend_next = scpi_pkg::ACT_INIT;
            scpi_pkg::CMD_FETC: pend_next = scpi_pkg::ACT_FETCH;
            default: pend_next = 3'h0;
         endcase
      end
   end

   wire param_data = acc && st_reg == scpi_pkg::ST_PARAM && !is_end;
   wire is_comma = char_data == scpi_pkg::CH_COMMA;
   wire rst_cmd = emit && !emit_err && emit_code == scpi_pkg::CMD_RST;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_reg <= scpi_pkg::ST_IDLE;
         {buf_reg, len_reg, depth_reg, pdepth_reg, p0_reg, p1_reg, p2_reg, par0_reg, par1_reg} <= '0;
         {query_reg, common_reg, first_reg, code_reg, pend_reg} <= '0;
         {cv_reg, ccode_reg, cq_reg, cc_reg, ce_reg, pv_reg, pc_reg, pf_reg, ps_reg} <= '0;
         {cfg_reg, init_reg, fetch_reg, avail_reg} <= '0;
         ready_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         {buf_reg, len_reg, depth_reg, pdepth_reg} <= {buf_next, len_next, depth_next, pdepth_next};
         {p0_reg, p1_reg, p2_reg, par0_reg, par1_reg} <= {p0_next, p1_next, p2_next, par0_next, par1_next};
         {query_reg, common_reg, first_reg, code_reg, pend_reg} <= {query_next, common_next, first_next, code_next,
                                                                    pend_next};
         {cv_reg, ccode_reg, cq_reg, cc_reg, ce_reg} <= {emit, emit_code, query_reg | hdr_query & in_name,
                                                         common_reg, emit_err};
         pv_reg <= param_data && !is_comma;
         pc_reg <= param_data ? char_data : pc_reg;
         pf_reg <= param_data && !is_comma && first_reg;
         ps_reg <= param_data && is_comma;
         cfg_reg <= pend_reg[2];
         init_reg <= pend_reg[1] && !pend_reg[2];
         fetch_reg <= pend_reg == scpi_pkg::ACT_FETCH;
         avail_reg <= (avail_reg || pend_reg == scpi_pkg::ACT_INIT || pend_reg == 3'h3) && !rst_cmd;
         ready_reg <= pend_next == 3'h0;
      end
   end

   assign char_ready = ready_reg;
   assign cmd_valid = cv_reg;
   assign cmd_code = ccode_reg;
   assign cmd_query = cq_reg;
   assign cmd_common = cc_reg;
   assign cmd_error = ce_reg;
   assign param_valid = pv_reg;
   assign param_char = pc_reg;
   assign param_first = pf_reg;
   assign param_sep = ps_reg;
   assign act_cfg = cfg_reg;
   assign act_init = init_reg;
   assign act_fetch = fetch_reg;
   assign data_avail = avail_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_meas_acts;
      act_cfg ##1 act_init && !act_cfg ##1 act_fetch && !act_init;
   endsequence
   sequence s_read_acts;
      !act_cfg && act_init ##1 act_fetch && !act_init;
   endsequence

   a_star_common: assert property (acc && st_reg == scpi_pkg::ST_IDLE && char_data == scpi_pkg::CH_STAR
      |=> st_reg == scpi_pkg::ST_COMMON && common_reg) else $error("asterisk did not open a common command");
   a_meas_order: assert property (cmd_valid && !cmd_error && cmd_code == scpi_pkg::CMD_MEAS
      |=> s_meas_acts) else $error("measure did not run configure, initiate, fetch");
   a_read_order: assert property (cmd_valid && !cmd_error && cmd_code == scpi_pkg::CMD_READ
      |=> s_read_acts) else $error("read did not run initiate then fetch");
   a_data_kept: assert property (data_avail && act_fetch && !cmd_valid |=> data_avail)
      else $error("fetch dropped the acquired data");
   a_space_param: assert property (acc && st_reg == scpi_pkg::ST_KEY && char_data == scpi_pkg::CH_SPACE
      && !hdr_bad |=> st_reg == scpi_pkg::ST_PARAM) else $error("space did not start parameters");
   a_comma_split: assert property (acc && st_reg == scpi_pkg::ST_PARAM && char_data == scpi_pkg::CH_COMMA
      |=> param_sep && !param_valid) else $error("comma did not split parameters");
   a_term_emits: assert property (acc && is_end && st_reg != scpi_pkg::ST_IDLE
      |=> cmd_valid ##1 !cmd_valid) else $error("terminator did not end the command");
   a_mid_length: assert property (acc && in_name && is_end && kw_bad
      |=> cmd_valid && cmd_error) else $error("partial keyword not reported as error");
   a_busy_stall: assert property (pend_reg != 3'h0 |-> !char_ready)
      else $error("characters taken while actions pending");
endmodule : scpi_header_parser
`default_nettype wire

/* File: verification/scpi_host_model.sv */
/*
 controller model: offers ASCII program messages one character at a time.
 assumes the parser shares clk and takes a character when char_ready is high.
*/
`timescale 1ns/1ps
`default_nettype none
module scpi_host_model (
   input wire logic clk,
   input wire logic char_ready,
   output logic char_valid,
   output logic [7:0] char_data
);
   initial begin
      char_valid = 1'b0;
      char_data = 8'h00;
   end
   // each character held until taken
   task automatic send(input string s);
      for (int i = 0; i < s.len(); i++) begin
         char_valid <= 1'b1;
         char_data <= s[i];
         @(posedge clk);
         while (char_ready !== 1'b1) @(posedge clk);
      end
      char_valid <= 1'b0;
      char_data <= ~char_data;
   endtask : send
endmodule : scpi_host_model
`default_nettype wire

/* File: verification/scpi_header_parser_tb.sv */
/*
 testbench of the command header parser: sends messages, logs pulses, compares.
 assumes the controller model in scpi_host_model.
*/
`timescale 1ns/1ps
`default_nettype none
module scpi_header_parser_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic char_valid, char_ready, cmd_valid, cmd_query, cmd_common, cmd_error;
   logic param_valid, param_first, param_sep, act_cfg, act_init, act_fetch, data_avail;
   logic [7:0] char_data, param_char, first_ch;
   logic [3:0] cmd_code;
   logic [6:0] cmds[$];
   logic [2:0] acts[$];
   int n_par, n_sep, n_busy, failures = 0, n_compared = 0;
   always #12.5 clk = ~clk;
   scpi_host_model i_scpi_host_model (.clk(clk), .char_ready(char_ready), .char_valid(char_valid),
      .char_data(char_data));
   scpi_header_parser i_scpi_header_parser (.clk(clk), .rst_n(rst_n), .char_valid(char_valid),
      .char_data(char_data), .char_ready(char_ready), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_query(cmd_query), .cmd_common(cmd_common), .cmd_error(cmd_error), .param_valid(param_valid),
      .param_char(param_char), .param_first(param_first), .param_sep(param_sep), .act_cfg(act_cfg),
      .act_init(act_init), .act_fetch(act_fetch), .data_avail(data_avail));
   // log of pulses
   always @(posedge clk) begin
      if (cmd_valid === 1'b1) cmds.push_back({cmd_error, cmd_common, cmd_query, cmd_code});
      if ({act_cfg, act_init, act_fetch} !== 3'h0) acts.push_back({act_cfg, act_init, act_fetch});
      if (param_valid === 1'b1) n_par++;
      if (param_sep === 1'b1) n_sep++;
      if (param_first === 1'b1) first_ch = param_char;
      if (char_ready !== 1'b1) n_busy++;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic run(input string s);
      cmds.delete();
      acts.delete();
      n_par = 0;
      n_sep = 0;
      n_busy = 0;
      i_scpi_host_model.send(s);
      repeat (8) @(posedge clk);
   endtask : run
   task automatic t_common;
      run("*IDN?\n");
      chk(cmds[0], 7'h3C);
      run("*ESE 32\n");
      chk(cmds[0], 7'h2E);
      chk(first_ch, 8'h33);
      chk(n_par, 2);
      run("*CLS\n");
      chk(cmds[0], 7'h2D);
      run("*TST?\n");
      chk(cmds[0], 7'h3A);
      run("*STB?\n");
      chk(cmds[0], 7'h3B);
   endtask : t_common
   task automatic t_path;
      run(":INP:COUP AC,DC\n");
      chk(cmds[0], 7'h01);
      chk(n_par, 4);
      chk(n_sep, 1);
      run(":INP:COUP?\n");
      chk(cmds[0], 7'h11);
   endtask : t_path
   task automatic t_forms;
      run(":inPUT:coupling?\n");
      chk(cmds[0], 7'h11);
      run(":INPU:COUP?\n");
      chk(cmds[0][6], 1'b1);
      run(":INP:COUPL\n");
      chk(cmds[0], 7'h40);
      run(":ROSC:SOUR EXT\n");
      chk(cmds[0], 7'h03);
      run(":INIT:IMM\n");
      chk(cmds[0], 7'h07);
   endtask : t_forms
   task automatic t_chain;
      run(":INP:COUP AC;IMP 1\n");
      chk(cmds.size(), 2);
      chk(cmds[1], 7'h02);
   endtask : t_chain
   task automatic t_meas;
      run("*RST\n");
      chk(cmds[0], 7'h29);
      chk(data_avail, 1'b0);
      run(":MEAS?\n");
      chk(cmds[0], 7'h14);
      chk(acts.size(), 3);
      chk(acts[0], 3'h4);
      chk(acts[1], 3'h2);
      chk(acts[2], 3'h1);
      chk(n_busy, 3);
      run(":READ?\n");
      chk(acts.size(), 2);
      chk(acts[0], 3'h2);
      chk(acts[1], 3'h1);
      chk(n_busy, 2);
      run(":FETC?\n");
      run(":FETC?\n");
      chk({acts.size(), acts[0], data_avail}, 36'h1_3);
      run(":CONF\n");
      chk(cmds[0], 7'h05);
      chk(acts.size(), 1);
      chk(acts[0], 3'h4);
      chk(n_busy, 1);
   endtask : t_meas
   task automatic give_verdict;
      $display("compared=%0d failures=%0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      give_verdict();
   end
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_common();
      t_path();
      t_forms();
      t_chain();
      t_meas();
      give_verdict();
   end
endmodule : scpi_header_parser_tb
`default_nettype wire
